/* rtl/uart_irq_wake_baud_ctrl.sv */
// UART interrupt, address detect, wake-up and baud control
`timescale 1ns/1ps
`default_nettype none
module uart_irq_wake_baud_ctrl
   import uart_irq_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wrData,
   input  wire logic       wrStrobe,
   input  wire logic       rdStrobe,
   output logic [7:0]      rdData,
   input  wire logic       rxPin,
   input  wire logic       rxWordValid,
   input  wire logic [7:0] rxWord,
   input  wire logic       rxNinth,
   input  wire logic       overrunIn,
   input  wire logic       txIdleIn,
   input  wire logic       txEmptyIn,
   output logic            rxWordAccept,
   output logic            txLoad,
   output logic [8:0]      txWord,
   output logic            baudTick,
   output logic            unitEnable,
   output logic            unitClockOn,
   output logic            uartIrqReq,
   output logic            irq
);
   // ****************************************
   // Registers
   // ****************************************
   logic [7:0]      ctrlA;
   logic [7:0]      ctrlB;
   logic [7:0]      dataBuf;
   logic [7:0]      baudDiv;
   logic            rxNinthBit;
   logic            rxAvail;
   logic            overrun;
   logic [EV_W-1:0] evStat;
   logic [EV_W-1:0] evMask;
   logic            clkOn;
   logic            rxMeta;
   logic            rxSync;
   logic            rxPrev;
   logic            wrHit;
   logic            addrBit;
   logic            wordKeep;
   logic            wakeEdge;
   logic            reqComb;
   logic [EV_W-1:0] evSet;
   logic [EV_W-1:0] evClr;

   assign unitEnable  = ctrlA[B_UNIT_EN];
   assign unitClockOn = clkOn;
   assign wrHit       = wrStrobe;

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrlA   <= RST_CTRL_A;
         ctrlB   <= RST_CTRL_B;
         baudDiv <= RST_BAUD;
         evMask  <= RST_MASK;
         clkOn   <= 1'b1;
      end else if (wrHit) begin
         case (addr)
            OFS_CTRL_A:   ctrlA   <= wrData;
            OFS_CTRL_B:   ctrlB   <= wrData;
            OFS_BAUD:     baudDiv <= wrData;
            OFS_IRQ_MASK: evMask  <= wrData[EV_W-1:0];
            OFS_CLK_CTRL: clkOn   <= wrData[0];
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // Address detect and shared data buffer
   // ****************************************
   assign addrBit  = ctrlA[B_NINE_BIT] ? rxNinth : rxWord[7];
   assign wordKeep = !ctrlB[B_ADDR_EN] || addrBit;
   assign rxWordAccept = rxWordValid && unitEnable && clkOn;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dataBuf    <= RST_DATA;
         rxNinthBit <= 1'b0;
         txLoad     <= 1'b0;
         txWord     <= 9'h000;
      end else begin
         txLoad <= 1'b0;
         if (wrHit && addr == OFS_DATA) begin
            dataBuf <= wrData;
            txLoad  <= unitEnable;
            txWord  <= {ctrlA[B_NINE_BIT] & ctrlA[B_TX_NINTH], wrData};
         end else if (rxWordAccept && wordKeep) begin
            dataBuf    <= rxWord;
            rxNinthBit <= ctrlA[B_NINE_BIT] & rxNinth;
         end
      end
   end

   // Receive flags; disabling the unit clears them
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rxAvail <= 1'b0;
         overrun <= 1'b0;
      end else if (!unitEnable) begin
         rxAvail <= 1'b0;
         overrun <= 1'b0;
      end else begin
         if (rxWordAccept && wordKeep) begin
            rxAvail <= 1'b1;
            overrun <= overrun | rxAvail | overrunIn;
         end else if (rdStrobe && addr == OFS_DATA) begin
            rxAvail <= 1'b0;
         end
      end
   end

   // ****************************************
   // RX pin synchroniser and wake-up
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rxMeta <= 1'b1;
         rxSync <= 1'b1;
         rxPrev <= 1'b1;
      end else begin
         rxMeta <= rxPin;
         rxSync <= rxMeta;
         rxPrev <= rxSync;
      end
   end

   // Only with the unit clock stopped and wake enabled
   assign wakeEdge = rxPrev && !rxSync && ctrlB[B_WAKE_EN] && !clkOn;

   // ****************************************
   // Request flag and sticky events
   // ****************************************
   always_comb begin
      reqComb = 1'b0;
      if (ctrlB[B_RX_IE] && (rxAvail || overrun)) reqComb = 1'b1;
      if (ctrlB[B_IDLE_IE] && txIdleIn && unitEnable) reqComb = 1'b1;
      if (ctrlB[B_EMPTY_IE] && txEmptyIn && unitEnable) reqComb = 1'b1;
   end

   assign evSet[EV_REQ]  = reqComb;
   assign evSet[EV_ADDR] = rxWordAccept && ctrlB[B_ADDR_EN] && addrBit
                           && ctrlB[B_RX_IE];
   assign evSet[EV_WAKE] = wakeEdge;
   assign evSet[EV_DROP] = rxWordAccept && !wordKeep;
   assign evClr = (wrHit && addr == OFS_IRQ_STAT) ? wrData[EV_W-1:0] : '0;

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         evStat <= '0;
      end else begin
         evStat <= (evStat & ~evClr) | evSet;
      end
   end

   assign uartIrqReq = reqComb || (evStat[EV_ADDR] && ctrlB[B_RX_IE])
                       || (evStat[EV_WAKE] && ctrlB[B_WAKE_EN]);
   assign irq = |(evStat & evMask);

   // ****************************************
   // Register read port
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdData <= 8'h00;
      end else if (rdStrobe) begin
         case (addr)
            OFS_CTRL_A: rdData <= {ctrlA[7:2], rxNinthBit, 1'b0};
            OFS_CTRL_B: rdData <= ctrlB;
            OFS_DATA:   rdData <= dataBuf;
            OFS_BAUD:   rdData <= baudDiv;
            OFS_STATUS: rdData <= {4'h0, overrun, rxAvail, txIdleIn, txEmptyIn};
            OFS_IRQ_STAT: rdData <= {4'h0, evStat};
            OFS_IRQ_MASK: rdData <= {4'h0, evMask};
            OFS_CLK_CTRL: rdData <= {7'h00, clkOn};
            default:    rdData <= 8'h00;
         endcase
      end else begin
         rdData <= 8'h00;
      end
   end

   // ****************************************
   // Baud generator
   // ****************************************
   baud_tick_gen u_baud (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .clear     (!unitEnable || !clkOn),
      .highSpeed (ctrlB[B_HIGH_SPEED]),
      .divisor   (baudDiv),
      .baudTick  (baudTick)
   );

   // ****************************************
   // Assertions
   // ****************************************
   a_drop_no_addr: assert property (@(posedge ref_clk) disable iff (rst)
      rxWordAccept && ctrlB[B_ADDR_EN] && !addrBit |=> !evStat[EV_ADDR] || $past(evStat[EV_ADDR]))
      else $error("Non-address word flagged as address");
   a_addr_event: assert property (@(posedge ref_clk) disable iff (rst)
      rxWordAccept && ctrlB[B_ADDR_EN] && addrBit && ctrlB[B_RX_IE] |=> evStat[EV_ADDR])
      else $error("Address word did not raise event");
   a_wake_edge: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(rxSync) && ctrlB[B_WAKE_EN] && !clkOn |=> evStat[EV_WAKE])
      else $error("Wake edge missed");
   a_wake_clk_on: assert property (@(posedge ref_clk) disable iff (rst)
      clkOn && !evStat[EV_WAKE] |=> !evStat[EV_WAKE])
      else $error("Wake while clock runs");
   a_wake_off: assert property (@(posedge ref_clk) disable iff (rst)
      !ctrlB[B_WAKE_EN] && !evStat[EV_WAKE] |=> !evStat[EV_WAKE])
      else $error("Wake with enable clear");
   a_rx_req: assert property (@(posedge ref_clk) disable iff (rst)
      ctrlB[B_RX_IE] && rxAvail |-> uartIrqReq)
      else $error("Receive request missing");
   a_idle_req: assert property (@(posedge ref_clk) disable iff (rst)
      ctrlB[B_IDLE_IE] && txIdleIn && unitEnable |-> uartIrqReq)
      else $error("Idle request missing");
   a_empty_req: assert property (@(posedge ref_clk) disable iff (rst)
      ctrlB[B_EMPTY_IE] && txEmptyIn && unitEnable |-> uartIrqReq)
      else $error("Empty request missing");
   a_disable_clr: assert property (@(posedge ref_clk) disable iff (rst)
      !unitEnable |=> !rxAvail && !overrun)
      else $error("Flags survive unit disable");
   a_data_write: assert property (@(posedge ref_clk) disable iff (rst)
      wrStrobe && addr == OFS_DATA |=> dataBuf == $past(wrData))
      else $error("Data register write lost");
   a_addr_keep: assert property (@(posedge ref_clk) disable iff (rst)
      rxWordAccept && ctrlB[B_ADDR_EN] && addrBit |=> rxAvail)
      else $error("Address word not kept");
   a_drop_no_avail: assert property (@(posedge ref_clk) disable iff (rst)
      rxWordAccept && ctrlB[B_ADDR_EN] && !addrBit && !rxAvail |=> !rxAvail)
      else $error("Dropped word marked available");
   a_drop_data_kept: assert property (@(posedge ref_clk) disable iff (rst)
      rxWordAccept && ctrlB[B_ADDR_EN] && !addrBit && !(wrStrobe && addr == OFS_DATA)
      |=> $stable(dataBuf))
      else $error("Dropped word reached data register");
   a_drop_event: assert property (@(posedge ref_clk) disable iff (rst)
      rxWordAccept && ctrlB[B_ADDR_EN] && !addrBit |=> evStat[EV_DROP])
      else $error("Dropped word not recorded");
   a_wake_irq: assert property (@(posedge ref_clk) disable iff (rst)
      evStat[EV_WAKE] && ctrlB[B_WAKE_EN] |-> uartIrqReq)
      else $error("Wake request without interrupt");
   a_wake_sticky: assert property (@(posedge ref_clk) disable iff (rst)
      evStat[EV_WAKE] && !(wrStrobe && addr == OFS_IRQ_STAT && wrData[EV_WAKE])
      |=> evStat[EV_WAKE])
      else $error("Wake event lost without clear");
   a_over_req: assert property (@(posedge ref_clk) disable iff (rst)
      ctrlB[B_RX_IE] && overrun |-> uartIrqReq)
      else $error("Overrun request missing");
   a_idle_off: assert property (@(posedge ref_clk) disable iff (rst)
      !ctrlB[B_IDLE_IE] && !ctrlB[B_EMPTY_IE] && !rxAvail && !overrun |-> !reqComb)
      else $error("Disabled source reached request");
   a_req_gated: assert property (@(posedge ref_clk) disable iff (rst)
      !ctrlB[B_RX_IE] && !ctrlB[B_IDLE_IE] && !ctrlB[B_EMPTY_IE]
      && !ctrlB[B_WAKE_EN] |-> !uartIrqReq)
      else $error("Request with every source disabled");
   a_tx_nine: assert property (@(posedge ref_clk) disable iff (rst)
      wrStrobe && addr == OFS_DATA |=> txWord ==
      {$past(ctrlA[B_NINE_BIT] & ctrlA[B_TX_NINTH]), $past(wrData)})
      else $error("Transmit word or ninth bit wrong");
   a_ninth_wo: assert property (@(posedge ref_clk) disable iff (rst)
      rdStrobe && addr == OFS_CTRL_A |=> !rdData[B_TX_NINTH])
      else $error("Write-only ninth bit readable");
   a_baud_clear: assert property (@(posedge ref_clk) disable iff (rst)
      !unitEnable |=> !baudTick)
      else $error("Baud tick while unit disabled");
   a_tick_pulse: assert property (@(posedge ref_clk) disable iff (rst)
      baudTick |=> !baudTick)
      else $error("Baud tick longer than one cycle");

   // ****************************************
   // Cover points
   // ****************************************
   c_addr_word: cover property (@(posedge ref_clk) evSet[EV_ADDR]);
   c_drop_word: cover property (@(posedge ref_clk) evSet[EV_DROP]);
   c_wake:      cover property (@(posedge ref_clk) evSet[EV_WAKE]);
   c_irq:       cover property (@(posedge ref_clk) irq);
   c_overrun:   cover property (@(posedge ref_clk) overrun);
endmodule : uart_irq_wake_baud_ctrl
`default_nettype wire

/* inc/uart_irq_pkg.sv */
// Package: register map, field positions, reset values and timing for the UART control block
package uart_irq_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [3:0] OFS_CTRL_A   = 4'h0;
   localparam logic [3:0] OFS_CTRL_B   = 4'h1;
   localparam logic [3:0] OFS_DATA     = 4'h2;
   localparam logic [3:0] OFS_BAUD     = 4'h3;
   localparam logic [3:0] OFS_STATUS   = 4'h4;
   localparam logic [3:0] OFS_IRQ_STAT = 4'h5;
   localparam logic [3:0] OFS_IRQ_MASK = 4'h6;
   localparam logic [3:0] OFS_CLK_CTRL = 4'h7;

   // ****************************************
   // Field positions
   // ****************************************
   // Control A
   localparam int B_UNIT_EN    = 7;
   localparam int B_NINE_BIT   = 6;
   localparam int B_RX_NINTH   = 1;
   localparam int B_TX_NINTH   = 0;
   // Control B
   localparam int B_HIGH_SPEED = 5;
   localparam int B_ADDR_EN    = 4;
   localparam int B_WAKE_EN    = 3;
   localparam int B_RX_IE      = 2;
   localparam int B_IDLE_IE    = 1;
   localparam int B_EMPTY_IE   = 0;
   // Status register
   localparam int B_OVERRUN    = 3;
   localparam int B_RX_AVAIL   = 2;
   localparam int B_TX_IDLE    = 1;
   localparam int B_TX_EMPTY   = 0;
   // Sticky event register
   localparam int EV_REQ       = 0;
   localparam int EV_ADDR      = 1;
   localparam int EV_WAKE      = 2;
   localparam int EV_DROP      = 3;
   localparam int EV_W         = 4;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] RST_CTRL_A = 8'h00;
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   localparam logic [7:0] RST_BAUD   = 8'h00;
   localparam logic [7:0] RST_DATA   = 8'h00;
   localparam logic [EV_W-1:0] RST_MASK = 4'h0;

   // ****************************************
   // Baud timing
   // ****************************************
   localparam int  CLK_HZ          = 50_000_000;
   localparam logic [6:0] DIV_LOW  = 7'd64;
   localparam logic [6:0] DIV_HIGH = 7'd16;
endpackage : uart_irq_pkg

/* rtl/baud_tick_gen.sv */
// Baud tick generator: prescaler plus 8-bit reload counter
`timescale 1ns/1ps
`default_nettype none
module baud_tick_gen
   import uart_irq_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       clear,
   input  wire logic       highSpeed,
   input  wire logic [7:0] divisor,
   output logic            baudTick
);
   logic [6:0] preCount;
   logic [7:0] mainCount;
   logic [6:0] preLast;
   logic       preTick;

   assign preLast = (highSpeed ? DIV_HIGH : DIV_LOW) - 7'd1;
   assign preTick = (preCount >= preLast);

   // Prescaler of 64 or 16 clocks
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         preCount <= 7'd0;
      end else if (clear || preTick) begin
         preCount <= 7'd0;
      end else begin
         preCount <= preCount + 7'd1;
      end
   end

   // Divide by N+1
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mainCount <= 8'd0;
         baudTick  <= 1'b0;
      end else if (clear) begin
         mainCount <= 8'd0;
         baudTick  <= 1'b0;
      end else begin
         baudTick <= 1'b0;
         if (preTick) begin
            if (mainCount >= divisor) begin
               mainCount <= 8'd0;
               baudTick  <= 1'b1;
            end else begin
               mainCount <= mainCount + 8'd1;
            end
         end
      end
   end
endmodule : baud_tick_gen
`default_nettype wire

/* dv/serial_node_model.sv */
// Remote serial node: hands received words over and drives the RX pin
`timescale 1ns/1ps
`default_nettype none
module serial_node_model (
   input  wire logic       ref_clk,
   output logic            rxPin,
   output logic            rxWordValid,
   output logic [7:0]      rxWord,
   output logic            rxNinth
);
   // ****************************************
   // Idle line
   // ****************************************
   initial begin
      rxPin       = 1'h1;
      rxWordValid = 1'h0;
      rxWord      = 8'h00;
      rxNinth     = 1'h0;
   end

   // ****************************************
   // Word delivery
   // ****************************************
   // Word and ninth bit valid for one cycle, then both driven inverted
   task automatic send_word(input logic [7:0] w, input logic n);
      @(posedge ref_clk);
      rxWordValid <= 1'h1;
      rxWord      <= w;
      rxNinth     <= n;
      @(posedge ref_clk);
      rxWordValid <= 1'h0;
      rxWord      <= ~w;
      rxNinth     <= ~n;
   endtask : send_word

   // Start bit: falling edge on an idle line
   task automatic start_edge();
      @(posedge ref_clk);
      rxPin <= 1'h0;
      repeat (3) @(posedge ref_clk);
      rxPin <= 1'h1;
   endtask : start_edge
endmodule : serial_node_model
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the UART interrupt, wake-up and baud control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin error_cnt++; \
   $display("[ERR] %0t mismatch got %h exp %h", $time, act, exp); end end
module testbench
   import uart_irq_pkg::*;
;
   logic       ref_clk, rst, wrStrobe, rdStrobe, rxPin, rxWordValid, rxNinth;
   logic       overrunIn, txIdleIn, txEmptyIn, rxWordAccept, txLoad, baudTick;
   logic       unitEnable, unitClockOn, uartIrqReq, irq;
   logic [3:0] addr;
   logic [7:0] wrData, rdData, rxWord, v;
   logic [8:0] txWord;
   int         error_cnt, n_checks, gap;
   // Rows: {enables[2:0], overrun, idle, empty, expected request}
   logic [6:0] rows [7] = '{7'h0e, 7'h75, 7'h46, 7'h25, 7'h2a, 7'h13, 7'h1c};

   uart_irq_wake_baud_ctrl i_uart_irq_wake_baud_ctrl (.ref_clk(ref_clk), .rst(rst),
      .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
      .rdData(rdData), .rxPin(rxPin), .rxWordValid(rxWordValid), .rxWord(rxWord),
      .rxNinth(rxNinth), .overrunIn(overrunIn), .txIdleIn(txIdleIn),
      .txEmptyIn(txEmptyIn), .rxWordAccept(rxWordAccept), .txLoad(txLoad),
      .txWord(txWord), .baudTick(baudTick), .unitEnable(unitEnable),
      .unitClockOn(unitClockOn), .uartIrqReq(uartIrqReq), .irq(irq));
   serial_node_model i_serial_node_model (.ref_clk(ref_clk), .rxPin(rxPin),
      .rxWordValid(rxWordValid), .rxWord(rxWord), .rxNinth(rxNinth));

   // ****************************************
   // Clock, bus tasks, closing
   // ****************************************
   always #10 ref_clk = ~ref_clk;

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr     <= a;
      wrData   <= d;
      wrStrobe <= 1'h1;
      @(posedge ref_clk);
      wrStrobe <= 1'h0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      addr     <= a;
      rdStrobe <= 1'h1;
      @(posedge ref_clk);
      rdStrobe <= 1'h0;
      #1;
      d = rdData;
   endtask : rd

   task automatic report_and_stop();
      $display("errors %0d checks %0d", error_cnt, n_checks);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   // Cycles between two baud ticks
   task automatic tick_gap(output int c);
      int k;
      k = 0;
      c = 1;
      while (baudTick !== 1'h1 && k < 2000) begin @(posedge ref_clk); #1; k++; end
      @(posedge ref_clk);
      #1;
      while (baudTick !== 1'h1 && c < 2000) begin @(posedge ref_clk); #1; c++; end
      if (k >= 2000 || c >= 2000) begin
         error_cnt++;
         report_and_stop();
      end
   endtask : tick_gap

   initial begin
      repeat (100000) @(posedge ref_clk);
      error_cnt++;
      report_and_stop();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      ref_clk = 1'h0; rst = 1'h1; addr = 4'h0; wrData = 8'h00;
      wrStrobe = 1'h0; rdStrobe = 1'h0;
      overrunIn = 1'h0; txIdleIn = 1'h0; txEmptyIn = 1'h0;
      error_cnt = 0; n_checks = 0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'h0;
      // Reset values and an unmapped index
      rd(OFS_CTRL_B, v); `CHK(v, RST_CTRL_B)
      rd(OFS_BAUD, v); `CHK(v, RST_BAUD)
      rd(OFS_IRQ_MASK, v); `CHK(v, 8'h00)
      `CHK(unitClockOn, 1'h1)
      wr(4'h9, 8'hff);
      rd(4'h9, v); `CHK(v, 8'h00)
      wr(OFS_CTRL_A, 8'h80);
      #1;
      `CHK(unitEnable, 1'h1)
      // Interrupt request gating table
      foreach (rows[i]) begin
         wr(OFS_CTRL_B, {5'h00, rows[i][6:4]});
         @(posedge ref_clk);
         {overrunIn, txIdleIn, txEmptyIn} <= rows[i][3:1];
         @(posedge ref_clk);
         #1;
         `CHK(uartIrqReq, rows[i][0])
      end
      {overrunIn, txIdleIn, txEmptyIn} <= 3'h0;
      // Transmit load in 9-bit mode, ninth bit write-only
      wr(OFS_CTRL_A, 8'hc1);
      wr(OFS_DATA, 8'h5a);
      #1;
      `CHK(txLoad, 1'h1)
      `CHK(txWord, 9'h15a)
      rd(OFS_CTRL_A, v); `CHK(v[B_TX_NINTH], 1'h0)
      // Address detect, 8-bit format
      wr(OFS_CTRL_A, 8'h80);
      wr(OFS_CTRL_B, 8'h14);
      wr(OFS_IRQ_STAT, 8'h0f);
      fork
         i_serial_node_model.send_word(8'h35, 1'h0);
         begin
            @(posedge ref_clk);
            #1;
            `CHK(rxWordAccept, 1'h1)
         end
      join
      rd(OFS_IRQ_STAT, v); `CHK(v[EV_DROP], 1'h1)
      `CHK(v[EV_ADDR], 1'h0)
      rd(OFS_STATUS, v); `CHK(v[B_RX_AVAIL], 1'h0)
      i_serial_node_model.send_word(8'ha5, 1'h0);
      rd(OFS_IRQ_STAT, v); `CHK(v[EV_ADDR], 1'h1)
      `CHK(uartIrqReq, 1'h1)
      rd(OFS_DATA, v); `CHK(v, 8'ha5)
      // Address detect, 9-bit format uses the ninth bit
      wr(OFS_CTRL_A, 8'hc0);
      wr(OFS_IRQ_STAT, 8'h0f);
      i_serial_node_model.send_word(8'h92, 1'h0);
      rd(OFS_IRQ_STAT, v); `CHK(v[EV_DROP], 1'h1)
      i_serial_node_model.send_word(8'h12, 1'h1);
      i_serial_node_model.send_word(8'h34, 1'h1);
      rd(OFS_STATUS, v); `CHK(v[B_OVERRUN], 1'h1)
      rd(OFS_CTRL_A, v); `CHK(v[B_RX_NINTH], 1'h1)
      rd(OFS_DATA, v); `CHK(v, 8'h34)
      // Overrun alone keeps the request up
      wr(OFS_IRQ_STAT, 8'h0f);
      #1;
      `CHK(uartIrqReq, 1'h1)
      // Unit disable clears receive flags
      wr(OFS_CTRL_A, 8'h00);
      #1;
      `CHK(unitEnable, 1'h0)
      rd(OFS_STATUS, v); `CHK(v[3:2], 2'h0)
      // Wake-up: ignored with the clock running
      wr(OFS_IRQ_STAT, 8'h0f);
      wr(OFS_CTRL_B, 8'h08);
      i_serial_node_model.start_edge();
      repeat (8) @(posedge ref_clk);
      rd(OFS_IRQ_STAT, v); `CHK(v[EV_WAKE], 1'h0)
      wr(OFS_CLK_CTRL, 8'h00);
      i_serial_node_model.start_edge();
      repeat (8) @(posedge ref_clk);
      rd(OFS_IRQ_STAT, v); `CHK(v[EV_WAKE], 1'h1)
      `CHK(uartIrqReq, 1'h1)
      #1;
      `CHK(irq, 1'h0)
      wr(OFS_IRQ_MASK, 8'h04);
      #1;
      `CHK(irq, 1'h1)
      wr(OFS_IRQ_STAT, 8'h04);
      #1;
      `CHK(irq, 1'h0)
      `CHK(uartIrqReq, 1'h0)
      wr(OFS_CTRL_B, 8'h00);
      i_serial_node_model.start_edge();
      repeat (8) @(posedge ref_clk);
      rd(OFS_IRQ_STAT, v); `CHK(v[EV_WAKE], 1'h0)
      wr(OFS_CLK_CTRL, 8'h01);
      // Baud divisor in both speed modes
      wr(OFS_CTRL_A, 8'h80);
      wr(OFS_BAUD, 8'h02);
      tick_gap(gap); `CHK(gap, 64 * 3)
      wr(OFS_CTRL_B, 8'h20);
      tick_gap(gap); `CHK(gap, 16 * 3)
      // Reset in mid-run returns registers to their reset values
      wr(OFS_IRQ_MASK, 8'h0f);
      rst <= 1'h1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'h0;
      rd(OFS_CTRL_A, v); `CHK(v, RST_CTRL_A)
      rd(OFS_IRQ_MASK, v); `CHK(v, {4'h0, RST_MASK})
      `CHK(irq, 1'h0)
      `CHK(baudTick, 1'h0)
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
